// ---- core/smc_top.sv ----
// Purpose: Power mode and CPU clock state controller with stop-mode pin hold.
// Assumes: Register writes and bus pin levels come from logic on clk_sys_i.
// Notes: The NMI pin and peripheral requests are asynchronous and synchronised here.
// How it works
// - Expansion modes in stop: bus pins hold, strobes and hold/bus clock high.
// - Single-chip mode in stop: all pins act as ports and hold, except a sub clock output, which goes high.
// - Clock output in stop: high for sub clock in single-chip, disabled in expansion; held for divided sources.
// - Stop ends on reset, NMI falling edge or enabled peripheral interrupt.
// - A peripheral wake requests its service routine once the clock runs, unless an NMI falling edge wakes in the same cycle.
// - After a wake from stop the CPU runs on sub clock, else main divided by eight.
// - Leaving stop forces the divide-by-eight bit to one.
// - Setting the main-clock-stop bit forces the divide-by-eight bit to one.
// - Sub clock may be selected only while its oscillator runs.
// - Only high/middle to low-speed to low-power moves, and back.
// - Clearing the main-clock-stop bit restarts the main oscillator.
// - Writing the stop request bit from any run mode enters stop.
// - Wait instruction enters wait; stop and wait never move directly.
// - A hardware interrupt returns stop or wait to the run mode.
// - Ratio: divide-by-eight bit, else pair gives 1, 2, 4 or 16.
// - Sub oscillator bit starts or stops it without touching the ratio.
// - In high/middle-speed any ratio may change to any other.
// - Register A holds oscillator and source bits, B stop and ratio bits.
// - A stop request also sets divide-by-eight and high drive.
`include "smc_map.svh"
module smc_top #(
  parameter int unsigned NUM_IRQ = 8,
  parameter int unsigned NUM_PORT = 8
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic wr_a_i,
  input wire logic [7:0] wdata_a_i,
  input wire logic wr_b_i,
  input wire logic [7:0] wdata_b_i,
  input wire logic wait_exec_i,
  input wire logic nmi_n_i,
  input wire logic [NUM_IRQ-1:0] periph_irq_i,
  input wire logic [NUM_IRQ*`SMC_PRIO_W-1:0] irq_priority_field_i,
  input wire logic irq_en_flag_i,
  input wire logic single_chip_i,
  input wire smc_pkg::smc_clock_output_pin_t clock_output_pin_sel_i,
  input wire logic [19:0] bus_addr_i,
  input wire logic [15:0] bus_data_i,
  input wire logic [3:0] chip_select_n_i,
  input wire logic byte_high_enable_i,
  input wire logic [3:0] bus_strobe_n_i,
  input wire logic hold_acknowledge_i,
  input wire logic bus_clk_i,
  input wire logic bus_ale_i,
  input wire logic clock_output_pin_i,
  input wire logic [NUM_PORT-1:0] port_i,
  output logic [7:0] rdata_a_o,
  output logic [7:0] rdata_b_o,
  output smc_pkg::smc_mode_t mode_o,
  output smc_pkg::smc_ratio_t cpu_div_o,
  output logic cpu_clk_tick_o,
  output logic cpu_clk_sub_o,
  output logic main_osc_en_o,
  output logic sub_osc_en_o,
  output logic main_osc_high_drive_o,
  output logic isr_req_o,
  output logic nmi_req_o,
  output logic [19:0] bus_addr_o,
  output logic [15:0] bus_data_o,
  output logic [3:0] chip_select_n_o,
  output logic byte_high_enable_o,
  output logic [3:0] bus_strobe_n_o,
  output logic hold_acknowledge_o,
  output logic bus_clk_o,
  output logic bus_ale_o,
  output logic clock_output_pin_o,
  output logic clock_output_oe_o,
  output logic [NUM_PORT-1:0] port_o
);
  import smc_pkg::*;

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  smc_if cif ();
  smc_mode_t state_q;
  smc_mode_t run_mode;
  logic [7:0] reg_a_q;
  logic [7:0] reg_b_q;
  logic [NUM_IRQ-1:0] irq_meta_q;
  logic [NUM_IRQ-1:0] irq_sync_q;
  logic [NUM_IRQ-1:0] irq_ok;
  logic nmi_meta_q;
  logic nmi_sync_q;
  logic nmi_prev_q;
  logic nmi_fall;
  logic periph_wake;
  logic wake;
  logic stopped;
  logic in_run;
  logic src_sel;
  logic main_stop;
  logic sub_on;
  logic src_new;
  logic mstop_new;
  logic sub_new;
  logic isr_q;
  logic nmi_q;

  assign src_sel = reg_a_q[`SMC_A_SRC_SEL];
  assign main_stop = reg_a_q[`SMC_A_MAIN_STOP];
  assign sub_on = reg_a_q[`SMC_A_SUB_ON];
  assign stopped = (state_q == ST_STOP);
  assign in_run = (state_q != ST_STOP) && (state_q != ST_WAIT);

  // -----------------------------------------------------------------
  // Wake sources
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      nmi_meta_q <= 1'b1;
      nmi_sync_q <= 1'b1;
      nmi_prev_q <= 1'b1;
      irq_meta_q <= '0;
      irq_sync_q <= '0;
    end
    else
    begin
      nmi_meta_q <= nmi_n_i;
      nmi_sync_q <= nmi_meta_q;
      nmi_prev_q <= nmi_sync_q;
      irq_meta_q <= periph_irq_i;
      irq_sync_q <= irq_meta_q;
    end
  end

  assign nmi_fall = nmi_prev_q && !nmi_sync_q;

  // A source whose priority field is zero cannot wake the device at all.
  for (genvar i = 0; i < NUM_IRQ; i++)
  begin : g_irq
    assign irq_ok[i] = irq_sync_q[i] && irq_en_flag_i
                       && (irq_priority_field_i[i*`SMC_PRIO_W +: `SMC_PRIO_W] != `SMC_PRIO_OFF);
  end

  assign periph_wake = |irq_ok;
  assign wake = nmi_fall || periph_wake;

  // -----------------------------------------------------------------
  // Clock control register A
  // -----------------------------------------------------------------
  // Moves that would leave the CPU without a running clock are refused.
  assign src_new = wdata_a_i[`SMC_A_SRC_SEL] ? sub_on : main_stop;
  assign mstop_new = wdata_a_i[`SMC_A_MAIN_STOP] && src_sel && src_new;
  assign sub_new = wdata_a_i[`SMC_A_SUB_ON] || src_new;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      reg_a_q <= `SMC_A_RST;
    else if (stopped)
    begin
      if (wake)
        reg_a_q[`SMC_A_DIV8] <= 1'b1;
    end
    else if (in_run)
    begin
      if (wr_a_i)
      begin
        reg_a_q[`SMC_A_SRC_SEL] <= src_new;
        reg_a_q[`SMC_A_MAIN_STOP] <= mstop_new;
        reg_a_q[`SMC_A_SUB_ON] <= sub_new;
        reg_a_q[`SMC_A_DIV8] <= wdata_a_i[`SMC_A_DIV8] || (mstop_new && !main_stop);
      end
      if (wr_b_i && wdata_b_i[`SMC_B_STOP_REQ])
        reg_a_q[`SMC_A_DIV8] <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Clock control register B
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      reg_b_q <= `SMC_B_RST;
    else if (stopped)
    begin
      if (wake)
        reg_b_q[`SMC_B_STOP_REQ] <= 1'b0;
    end
    else if (in_run && wr_b_i)
    begin
      reg_b_q[`SMC_B_DIV_LOW] <= wdata_b_i[`SMC_B_DIV_LOW];
      reg_b_q[`SMC_B_DIV_HIGH] <= wdata_b_i[`SMC_B_DIV_HIGH];
      reg_b_q[`SMC_B_HIGH_DRIVE] <= wdata_b_i[`SMC_B_HIGH_DRIVE] || wdata_b_i[`SMC_B_STOP_REQ];
      reg_b_q[`SMC_B_STOP_REQ] <= wdata_b_i[`SMC_B_STOP_REQ];
    end
  end

  // -----------------------------------------------------------------
  // Mode state
  // -----------------------------------------------------------------
  always_comb
  begin
    if (!src_sel)
      run_mode = ST_HIGH_MID;
    else if (main_stop)
      run_mode = ST_LOW_POWER;
    else
      run_mode = ST_LOW_SPEED;
  end

  // The stop bit is seen one edge after its write, so the write is always complete.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      state_q <= ST_HIGH_MID;
    else
    begin
      case (state_q)
        ST_STOP:
          if (wake)
            state_q <= run_mode;
        ST_WAIT:
          if (wake)
            state_q <= run_mode;
        default:
          if (reg_b_q[`SMC_B_STOP_REQ])
            state_q <= ST_STOP;
          else if (wait_exec_i)
            state_q <= ST_WAIT;
          else
            state_q <= run_mode;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      isr_q <= 1'b0;
      nmi_q <= 1'b0;
    end
    else
    begin
      isr_q <= !in_run && periph_wake && !nmi_fall;
      nmi_q <= !in_run && nmi_fall;
    end
  end

  // -----------------------------------------------------------------
  // CPU clock
  // -----------------------------------------------------------------
  always_comb
  begin
    if (reg_a_q[`SMC_A_DIV8])
      cif.ratio = DIV_8;
    else
    begin
      case ({reg_b_q[`SMC_B_DIV_HIGH], reg_b_q[`SMC_B_DIV_LOW]})
        2'h0: cif.ratio = DIV_1;
        2'h1: cif.ratio = DIV_2;
        2'h2: cif.ratio = DIV_4;
        default: cif.ratio = DIV_16;
      endcase
    end
  end

  assign cif.run = in_run;

  smc_div u_div (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .ctl(cif.div)
  );

  assign cpu_clk_tick_o = cif.tick;
  assign cpu_div_o = cif.ratio;
  assign cpu_clk_sub_o = src_sel;
  assign main_osc_en_o = !main_stop && !stopped;
  assign sub_osc_en_o = sub_on && !stopped;
  assign main_osc_high_drive_o = reg_b_q[`SMC_B_HIGH_DRIVE];
  assign rdata_a_o = reg_a_q & `SMC_A_MASK;
  assign rdata_b_o = reg_b_q & `SMC_B_MASK;
  assign mode_o = state_q;
  assign isr_req_o = isr_q;
  assign nmi_req_o = nmi_q;

  // -----------------------------------------------------------------
  // Pins in stop mode
  // -----------------------------------------------------------------
  // Address latch enable is undefined in stop; it is parked low here in expansion modes and held in single-chip mode.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      bus_addr_o <= '0;
      bus_data_o <= '0;
      chip_select_n_o <= '1;
      byte_high_enable_o <= 1'b1;
      bus_strobe_n_o <= '1;
      hold_acknowledge_o <= 1'b1;
      bus_clk_o <= 1'b1;
      bus_ale_o <= 1'b0;
      clock_output_pin_o <= 1'b0;
      clock_output_oe_o <= 1'b1;
      port_o <= '0;
    end
    else if (!stopped)
    begin
      bus_addr_o <= bus_addr_i;
      bus_data_o <= bus_data_i;
      chip_select_n_o <= chip_select_n_i;
      byte_high_enable_o <= byte_high_enable_i;
      bus_strobe_n_o <= bus_strobe_n_i;
      hold_acknowledge_o <= hold_acknowledge_i;
      bus_clk_o <= bus_clk_i;
      bus_ale_o <= bus_ale_i;
      clock_output_pin_o <= clock_output_pin_i;
      clock_output_oe_o <= 1'b1;
      port_o <= port_i;
    end
    else if (single_chip_i)
    begin
      if (clock_output_pin_sel_i == CO_SUB)
        clock_output_pin_o <= 1'b1;
    end
    else
    begin
      bus_strobe_n_o <= '1;
      hold_acknowledge_o <= 1'b1;
      bus_clk_o <= 1'b1;
      bus_ale_o <= 1'b0;
      clock_output_oe_o <= (clock_output_pin_sel_i != CO_SUB);
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  chk_stop_entry_delay: assert property ($rose(reg_b_q[`SMC_B_STOP_REQ]) |=> stopped)
    else $error("Stop not entered one cycle after the request.");
  chk_stop_side_bits: assert property ($rose(reg_b_q[`SMC_B_STOP_REQ])
    |-> reg_a_q[`SMC_A_DIV8] && reg_b_q[`SMC_B_HIGH_DRIVE])
    else $error("Stop request did not set divide-by-eight and high drive.");
  chk_exit_div_eight: assert property (stopped && wake |=> !stopped && reg_a_q[`SMC_A_DIV8])
    else $error("Stop exit did not force divide-by-eight.");
  chk_exit_clock_src: assert property ($fell(stopped)
    |-> cpu_clk_sub_o == $past(src_sel) && (cpu_clk_sub_o || cpu_div_o == DIV_8))
    else $error("Wrong CPU clock after stop exit.");
  chk_sub_osc_run: assert property (src_sel |-> sub_on)
    else $error("Sub clock selected while its oscillator is off.");
  chk_no_direct_move: assert property ((state_q == ST_HIGH_MID |=> state_q != ST_LOW_POWER)
    and (state_q == ST_LOW_POWER |=> state_q != ST_HIGH_MID))
    else $error("Direct move between high/middle-speed and low-power.");
  chk_mstop_div_eight: assert property ($rose(main_stop) |-> reg_a_q[`SMC_A_DIV8])
    else $error("Main clock stop without divide-by-eight.");
  chk_stop_frozen: assert property (stopped ##1 stopped |-> !cpu_clk_tick_o
    && $stable(reg_a_q) && $stable(reg_b_q))
    else $error("Clocked state moved while stopped.");
  chk_wait_no_stop: assert property (state_q == ST_WAIT |=> state_q != ST_STOP)
    else $error("Direct move from wait to stop.");
  chk_isr_after_wake: assert property (stopped && periph_wake && !nmi_fall
    |=> isr_req_o && in_run ##1 !isr_req_o)
    else $error("Peripheral wake did not request one service routine.");
  chk_strobe_high: assert property (stopped && $past(stopped) && !single_chip_i
    |-> bus_strobe_n_o == '1 && hold_acknowledge_o && bus_clk_o)
    else $error("Bus strobes not high in stop.");
  chk_mstop_restart: assert property ($fell(main_stop) && !stopped |-> main_osc_en_o)
    else $error("Main oscillator not restarted.");

  cov_stop_nmi: cover property (stopped ##1 nmi_fall ##1 !stopped);
  cov_stop_periph: cover property (stopped && periph_wake ##1 isr_req_o);
  cov_low_power: cover property (state_q == ST_LOW_SPEED ##1 state_q == ST_LOW_POWER);
  cov_wait_exit: cover property (state_q == ST_WAIT ##1 state_q != ST_WAIT);
endmodule : smc_top

// ---- inc/smc_map.svh ----
// Purpose: Bit positions, reset values and counts of the stop-mode clock controller.
// Assumes: Both clock control registers are eight bits wide.
// Notes: Definitions only.
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH
// -----------------------------------------------------------------
// Clock control register A
// -----------------------------------------------------------------
`define SMC_A_SUB_ON 4
`define SMC_A_MAIN_STOP 5
`define SMC_A_DIV8 6
`define SMC_A_SRC_SEL 7
`define SMC_A_RST 8'h40
`define SMC_A_MASK 8'hf0
// -----------------------------------------------------------------
// Clock control register B
// -----------------------------------------------------------------
`define SMC_B_STOP_REQ 0
`define SMC_B_HIGH_DRIVE 5
`define SMC_B_DIV_LOW 6
`define SMC_B_DIV_HIGH 7
`define SMC_B_RST 8'h20
`define SMC_B_MASK 8'he1
// -----------------------------------------------------------------
// Interrupt priority and divider limits
// -----------------------------------------------------------------
`define SMC_PRIO_W 3
`define SMC_PRIO_OFF 3'h0
`define SMC_LIM_DIV1 4'h0
`define SMC_LIM_DIV2 4'h1
`define SMC_LIM_DIV4 4'h3
`define SMC_LIM_DIV8 4'h7
`define SMC_LIM_DIV16 4'hf
`define SMC_CNT_ZERO 4'h0
`define SMC_CNT_ONE 4'h1
`endif

// ---- inc/smc_pkg.sv ----
// Purpose: Types shared by the stop-mode clock controller files.
// Assumes: Nothing beyond the map header.
// Notes: Types only; numbers live in the map header.
package smc_pkg;
  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {ST_HIGH_MID, ST_LOW_SPEED, ST_LOW_POWER, ST_STOP, ST_WAIT} smc_mode_t;
  typedef enum logic [2:0] {DIV_1, DIV_2, DIV_4, DIV_8, DIV_16} smc_ratio_t;
  typedef enum logic [1:0] {CO_SUB, CO_DIV8, CO_DIV32} smc_clock_output_pin_t;
endpackage : smc_pkg

// ---- inc/smc_if.sv ----
// Purpose: Carries the division ratio and run state to the CPU clock divider.
// Assumes: One clock domain.
// Notes: The controller drives ratio and run, the divider answers with tick.
interface smc_if;
  smc_pkg::smc_ratio_t ratio;
  logic run;
  logic tick;
  modport ctl (output ratio, output run, input tick);
  modport div (input ratio, input run, output tick);
endinterface : smc_if

// ---- core/smc_div.sv ----
// Purpose: CPU clock divider producing one enable tick per divided period.
// Assumes: Ratio changes may land at any count.
// Notes: The count holds while the clock is not supplied.
`include "smc_map.svh"
module smc_div (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  smc_if.div ctl
);
  import smc_pkg::*;
  logic [3:0] cnt_q;
  logic [3:0] lim;

  always_comb
  begin
    case (ctl.ratio)
      DIV_1: lim = `SMC_LIM_DIV1;
      DIV_2: lim = `SMC_LIM_DIV2;
      DIV_4: lim = `SMC_LIM_DIV4;
      DIV_8: lim = `SMC_LIM_DIV8;
      DIV_16: lim = `SMC_LIM_DIV16;
      default: lim = `SMC_LIM_DIV8;
    endcase
  end

  // Holding rather than clearing keeps stop and wait free of any clock phase jump.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      cnt_q <= `SMC_CNT_ZERO;
    else if (ctl.run)
      cnt_q <= (cnt_q >= lim) ? `SMC_CNT_ZERO : cnt_q + `SMC_CNT_ONE;
  end

  assign ctl.tick = ctl.run && (cnt_q >= lim);
endmodule : smc_div

// ---- testbench/smc_wake_model.sv ----
// Purpose: Model of CPU software and waking sources around the controller.
// Assumes: The bench picks the waking sources before it asks for stop.
// Notes: Every source line rises on a fire, so unprogrammed ones test refusal.
`include "smc_map.svh"
module smc_wake_model #(
  parameter int unsigned NUM_IRQ = 8
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [NUM_IRQ-1:0] wake_sel_i,
  input wire logic fire_i,
  input wire logic nmi_fire_i,
  input wire logic ack_i,
  output logic [NUM_IRQ-1:0] periph_irq_o = '0,
  output logic [NUM_IRQ*`SMC_PRIO_W-1:0] prio_o,
  output logic irq_en_flag_o,
  output logic nmi_n_o = 1'b1
);
  timeunit 1ns;
  timeprecision 100ps;
  // -----------------------------------------------------------------
  // Software set-up before stop
  // -----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      prio_o[`SMC_PRIO_W*i +: `SMC_PRIO_W] = wake_sel_i[i] ? 3'h2 : `SMC_PRIO_OFF;
    end
    irq_en_flag_o = |wake_sel_i;
  end
  // -----------------------------------------------------------------
  // Request lines
  // -----------------------------------------------------------------
  // Requests stay up until served, as a real level source would.
  always @(posedge clk_sys_i)
  begin
    if (srst_i || ack_i)
    begin
      periph_irq_o <= '0;
      nmi_n_o <= 1'b1;
    end
    else
    begin
      if (fire_i)
        periph_irq_o <= '1;
      if (nmi_fire_i)
        nmi_n_o <= 1'b0;
    end
  end
endmodule : smc_wake_model

// ---- testbench/stop_mode_clock_state_control_tb_top.sv ----
// Purpose: Self-checking bench of the stop-mode clock controller.
// Assumes: Default parameters, expansion mode unless a test says otherwise.
// Notes: Inputs move 1 ns after the rising edge.
module stop_mode_clock_state_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import smc_pkg::*;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, wr_a_i = 1'b0, wr_b_i = 1'b0, wait_exec_i = 1'b0;
  logic [7:0] wdata_a_i = 8'h00, wdata_b_i = 8'h00, port_i = 8'h00, wake_sel = 8'h00;
  logic single_chip_i = 1'b0, fire = 1'b0, nmi_fire = 1'b0, nmi_n_i, irq_en_flag_i;
  logic byte_high_enable_i = 1'b0, hold_acknowledge_i = 1'b0, bus_clk_i = 1'b0;
  logic bus_ale_i = 1'b0, clock_output_pin_i = 1'b0, hold_acknowledge_o, bus_clk_o;
  smc_clock_output_pin_t clock_output_pin_sel_i = CO_SUB;
  logic [19:0] bus_addr_i = 20'h00000, bus_addr_o;
  logic [15:0] bus_data_i = 16'h0000, bus_data_o;
  logic [3:0] chip_select_n_i = 4'h0, bus_strobe_n_i = 4'h0, bus_strobe_n_o, chip_select_n_o;
  logic [7:0] periph_irq_i, rdata_a_o, rdata_b_o, port_o;
  logic [23:0] irq_priority_field_i;
  smc_mode_t mode_o;
  smc_ratio_t cpu_div_o;
  logic cpu_clk_tick_o, cpu_clk_sub_o, main_osc_en_o, sub_osc_en_o, isr_req_o, nmi_req_o;
  logic clock_output_pin_o, clock_output_oe_o, byte_high_enable_o, bus_ale_o, main_osc_high_drive_o;
  int mismatches = 0, checked = 0;
  smc_top u_dut (.clk_sys_i, .srst_i, .wr_a_i, .wdata_a_i, .wr_b_i, .wdata_b_i,
    .wait_exec_i, .nmi_n_i, .periph_irq_i, .irq_priority_field_i, .irq_en_flag_i,
    .single_chip_i, .clock_output_pin_sel_i, .bus_addr_i, .bus_data_i, .chip_select_n_i,
    .byte_high_enable_i, .bus_strobe_n_i, .hold_acknowledge_i, .bus_clk_i, .bus_ale_i,
    .clock_output_pin_i, .port_i, .rdata_a_o, .rdata_b_o, .mode_o, .cpu_div_o,
    .cpu_clk_tick_o, .cpu_clk_sub_o, .main_osc_en_o, .sub_osc_en_o,
    .main_osc_high_drive_o, .isr_req_o, .nmi_req_o, .bus_addr_o, .bus_data_o,
    .chip_select_n_o, .byte_high_enable_o, .bus_strobe_n_o, .hold_acknowledge_o,
    .bus_clk_o, .bus_ale_o, .clock_output_pin_o, .clock_output_oe_o, .port_o);
  smc_wake_model u_src (.clk_sys_i, .srst_i, .wake_sel_i(wake_sel), .fire_i(fire),
    .nmi_fire_i(nmi_fire), .ack_i(isr_req_o | nmi_req_o), .periph_irq_o(periph_irq_i),
    .prio_o(irq_priority_field_i), .irq_en_flag_o(irq_en_flag_i), .nmi_n_o(nmi_n_i));
  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  always #4 clk_sys_i = ~clk_sys_i;
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : step
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp
  // Each write lets a spare edge pass so a strobe is never raised twice at once.
  task automatic wr_a(input logic [7:0] d);
    wdata_a_i = d;
    wr_a_i = 1'b1;
    step(1);
    wr_a_i = 1'b0;
    step(1);
  endtask : wr_a
  task automatic wr_b(input logic [7:0] d);
    wdata_b_i = d;
    wr_b_i = 1'b1;
    step(1);
    wr_b_i = 1'b0;
    step(1);
  endtask : wr_b
  task automatic pulse_fire();
    fire = 1'b1;
    step(1);
    fire = 1'b0;
  endtask : pulse_fire
  task automatic wait_wake(input logic nmi);
    int n;
    n = 0;
    while (isr_req_o !== 1'b1 && nmi_req_o !== 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
    cmp("wake pulse", {nmi, !nmi}, {nmi_req_o, isr_req_o});
  endtask : wait_wake
  task automatic test_done();
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    int n;
    n = 0;
    cmp("reg a", 8'h40, rdata_a_o);
    cmp("reg b", 8'h20, rdata_b_o);
    cmp("mode", ST_HIGH_MID, mode_o);
    cmp("ratio", DIV_8, cpu_div_o);
    repeat (16)
    begin
      n += cpu_clk_tick_o;
      step(1);
    end
    cmp("ticks", 32'h2, n);
  endtask : t_reset
  task automatic t_ratio();
    smc_ratio_t exp [4];
    exp = '{DIV_1, DIV_2, DIV_4, DIV_16};
    wr_a(8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr_b({k[1:0], 6'h20});
      cmp("ratio", exp[k], cpu_div_o);
    end
    wr_a(8'h10);
    cmp("sub osc", 1'b1, sub_osc_en_o);
    cmp("ratio", DIV_16, cpu_div_o);
    wr_a(8'h40);
    cmp("ratio", DIV_8, cpu_div_o);
  endtask : t_ratio
  task automatic t_modes();
    wr_a(8'hc0);
    cmp("reg a", 8'h40, rdata_a_o);
    wr_a(8'h60);
    cmp("main osc", 1'b1, main_osc_en_o);
    wr_a(8'h50);
    wr_a(8'hd0);
    cmp("mode", ST_LOW_SPEED, mode_o);
    cmp("on sub", 1'b1, cpu_clk_sub_o);
    wr_a(8'hb0);
    cmp("reg a", 8'hf0, rdata_a_o);
    cmp("mode", ST_LOW_POWER, mode_o);
    cmp("main osc", 1'b0, main_osc_en_o);
    wr_a(8'h90);
    cmp("main osc", 1'b1, main_osc_en_o);
    cmp("mode", ST_LOW_SPEED, mode_o);
  endtask : t_modes
  task automatic t_stop_irq();
    bus_addr_i = 20'h12345;
    bus_data_i = 16'h1234;
    bus_ale_i = 1'b1;
    wake_sel = 8'h01;
    wr_b(8'h00);
    cmp("high drive", 1'b0, main_osc_high_drive_o);
    wr_b(8'h01);
    cmp("reg b", 8'h21, rdata_b_o & 8'h21);
    cmp("high drive", 1'b1, main_osc_high_drive_o);
    cmp("reg a", 8'hd0, rdata_a_o);
    cmp("mode", ST_STOP, mode_o);
    cmp("osc", 3'h0, {cpu_clk_tick_o, main_osc_en_o, sub_osc_en_o});
    bus_addr_i = 20'h0abcd;
    bus_data_i = 16'h4321;
    chip_select_n_i = 4'hf;
    byte_high_enable_i = 1'b1;
    wr_a(8'h00);
    cmp("addr", 20'h12345, bus_addr_o);
    cmp("bus hold", {16'h1234, 4'h0, 1'b0}, {bus_data_o, chip_select_n_o, byte_high_enable_o});
    cmp("strobes", 7'h7e, {bus_strobe_n_o, hold_acknowledge_o, bus_clk_o, bus_ale_o});
    cmp("clock_output_pin oe", 1'b0, clock_output_oe_o);
    pulse_fire();
    wait_wake(1'b0);
    cmp("mode", ST_LOW_SPEED, mode_o);
    cmp("on sub", 1'b1, cpu_clk_sub_o);
    cmp("reg a", 8'hd0, rdata_a_o);
  endtask : t_stop_irq
  task automatic t_stop_nmi();
    wr_a(8'h50);
    single_chip_i = 1'b1;
    wake_sel = 8'h00;
    port_i = 8'h5a;
    step(2);
    wr_b(8'h01);
    port_i = 8'ha5;
    pulse_fire();
    step(10);
    cmp("mode", ST_STOP, mode_o);
    cmp("ports", 8'h5a, port_o);
    cmp("clock_output_pin", 1'b1, clock_output_pin_o);
    nmi_fire = 1'b1;
    step(1);
    nmi_fire = 1'b0;
    wait_wake(1'b1);
    cmp("mode", ST_HIGH_MID, mode_o);
    cmp("ratio", DIV_8, cpu_div_o);
    cmp("on sub", 1'b0, cpu_clk_sub_o);
  endtask : t_stop_nmi
  task automatic t_wait();
    // Requests from the last wake still sit in the synchroniser; let them drain first.
    step(4);
    wake_sel = 8'h02;
    wait_exec_i = 1'b1;
    step(1);
    wait_exec_i = 1'b0;
    cmp("mode", ST_WAIT, mode_o);
    wr_b(8'h01);
    cmp("mode", ST_WAIT, mode_o);
    pulse_fire();
    wait_wake(1'b0);
    cmp("mode", ST_HIGH_MID, mode_o);
    cmp("stop bit", 1'b0, rdata_b_o[0]);
  endtask : t_wait
  // -----------------------------------------------------------------
  // Main sequence and watchdog
  // -----------------------------------------------------------------
  initial
  begin
    step(8);
    srst_i = 1'b0;
    step(1);
    t_reset();
    t_ratio();
    t_modes();
    t_stop_irq();
    t_stop_nmi();
    t_wait();
    test_done();
  end
  // The tests need well under a thousand cycles.
  initial
  begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule : stop_mode_clock_state_control_tb_top
